// [core/maint_port.sv]
// Maintenance serial port: AXI4-Lite registers, setting sets,
// select input, receive timeout, one character each way.
// Assumes load requests arrive on aclk; rxd and mode_in are pins.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module maint_port import maint_port_pkg::*; #(
  parameter int unsigned SLOT = 0,
  parameter int unsigned FW_REV = 220,
  parameter bit FAST_MODULE = 1'b1,
  parameter int unsigned STEP_CYCLES = TIMEOUT_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic txd,
  input wire logic [15:0] mode_in,
  output logic [4:0] net_number
);

  // ********************
  // State
  // ********************
  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [7:0] awaddr;
    logic wready;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] cfg;
    logic [7:0] tmo;
    logic [4:0] net;
    logic [4:0] sel;
    logic [6:0] cfg_s;
    logic [7:0] tmo_s;
    logic [4:0] net_s;
    logic [4:0] sel_s;
    logic [6:0] act_cfg;
    logic [7:0] act_tmo;
    logic [4:0] act_net;
    logic perr;
    logic tmo_err;
    logic rej;
    logic fast_rej;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_start;
    logic [7:0] tx_data;
    logic rx_m;
    logic rx_s;
    logic [15:0] mi_m;
    logic [15:0] mi_s;
    logic armed;
    logic [31:0] tick;
    logic [7:0] units;
  } top_s;

  localparam top_s Q_RST = '{
    cfg: CFG_RESET, cfg_s: CFG_RESET, act_cfg: CFG_RESET,
    tmo: TMO_RESET, tmo_s: TMO_RESET, act_tmo: TMO_RESET,
    net: NET_RESET, net_s: NET_RESET, act_net: NET_RESET,
    sel: SEL_RESET, sel_s: SEL_RESET,
    rx_m: 1'b1, rx_s: 1'b1, default: '0};

  localparam logic [2:0] PORT_NUM = 3'(FIRST_PORT + SLOT);         // [R01]
  localparam bit FAST_OK = (FW_REV >= FW_FAST_MIN) && FAST_MODULE;

  top_s q;
  top_s d;
  logic tx_busy;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_perr;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic [6:0] new_cfg;
  logic [2:0] load_src;
  logic use_stored;
  logic [31:0] stat_word;

  // ********************
  // Character engines
  // ********************
  // Both engines run from the active set.
  // A set change in mid-character is not deferred,
  // so it may corrupt that one character.
  serial_tx u_serial_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(BAUD_DIV[q.act_cfg[CFG_BAUD_LSB +: 3]]),                 // [R02]
    .data8(q.act_cfg[CFG_DATA8_BIT]),
    .parity(q.act_cfg[CFG_PAR_LSB +: 2]),
    .stop2(q.act_cfg[CFG_STOP2_BIT]),
    .start(q.tx_start),
    .data(q.tx_data),
    .txd(txd),
    .busy(tx_busy)
  );

  serial_rx u_serial_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(BAUD_DIV[q.act_cfg[CFG_BAUD_LSB +: 3]]),                 // [R02]
    .data8(q.act_cfg[CFG_DATA8_BIT]),
    .parity(q.act_cfg[CFG_PAR_LSB +: 2]),
    .rxd(q.rx_s),
    .done(rx_done),
    .data(rx_byte),
    .perr(rx_perr)
  );

  // ********************
  // Next-state logic
  // ********************
  // Bus accesses first, events last:
  // a flag set and cleared in one cycle stays set.
  always_comb begin
    d = q;
    wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    merged = 32'h0;
    new_cfg = q.cfg;
    load_src = q.wdata[2:0];
    d.tx_start = 1'b0;
    stat_word = {23'h0, q.fast_rej, tx_busy, q.rx_valid, q.rej, q.tmo_err, q.perr,
                 PORT_NUM};

    // Pin synchronisers: the first stage feeds only the second.
    d.rx_m = rxd;
    d.rx_s = q.rx_m;
    d.mi_m = mode_in;
    d.mi_s = q.mi_m;

    // AW and W are taken in either order and held.
    if (awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    // Perform the write once both halves are held and no response is pending.
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.awaddr)
        ADDR_CFG: begin
          merged = (32'(q.cfg) & ~wmask) | (q.wdata & wmask);
          new_cfg = merged[6:0];
          // A refused fast rate keeps the old rate.
          if (!FAST_OK && new_cfg[CFG_BAUD_LSB +: 3] >= BAUD_FAST_MIN) begin
            new_cfg[CFG_BAUD_LSB +: 3] = q.cfg[CFG_BAUD_LSB +: 3];   // [R15]
            d.fast_rej = 1'b1;                                       // [R15]
          end
          d.cfg = new_cfg;                                           // [R03] [R04] [R05]
        end
        ADDR_TMO: begin
          merged = (32'(q.tmo) & ~wmask) | (q.wdata & wmask);
          d.tmo = merged[7:0];                                       // [R06]
        end
        ADDR_NET: begin
          merged = (32'(q.net) & ~wmask) | (q.wdata & wmask);
          d.net = merged[4:0];                                       // [R08]
        end
        ADDR_SEL: begin
          merged = (32'(q.sel) & ~wmask) | (q.wdata & wmask);
          d.sel = merged[4:0];                                       // [R09]
        end
        ADDR_LOAD: begin
          // Only a built-in port may load a new set.
          if (q.wstrb[0] && (load_src == LOAD_PORT_A || load_src == LOAD_PORT_B)) begin
            d.cfg_s = q.cfg;                                         // [R11] [R12]
            d.tmo_s = q.tmo;                                         // [R12]
            d.net_s = q.net;                                         // [R12]
            d.sel_s = q.sel;                                         // [R12]
          end else if (q.wstrb[0]) begin
            d.rej = 1'b1;                                            // [R11] [R13]
          end
        end
        ADDR_STAT: begin
          merged = q.wdata & wmask;
          if (merged[ST_PERR_BIT]) begin
            d.perr = 1'b0;
          end
          if (merged[ST_TMO_BIT]) begin
            d.tmo_err = 1'b0;
          end
          if (merged[ST_REJ_BIT]) begin
            d.rej = 1'b0;
          end
          if (merged[ST_FAST_BIT]) begin
            d.fast_rej = 1'b0;
          end
        end
        ADDR_DATA: begin
          // A byte written while a character is still going out is dropped.
          if (q.wstrb[0] && !tx_busy && !q.tx_start) begin
            d.tx_start = 1'b1;                                       // [R13]
            d.tx_data = q.wdata[7:0];
          end
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel: one read at a time, answered the cycle after it is taken.
    if (rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (araddr)
        ADDR_CFG: d.rdata = 32'(q.cfg);
        ADDR_TMO: d.rdata = 32'(q.tmo);
        ADDR_NET: d.rdata = 32'(q.net);
        ADDR_SEL: d.rdata = 32'(q.sel);
        ADDR_LOAD: d.rdata = 32'h0;
        ADDR_STAT: d.rdata = stat_word;                              // [R01]
        ADDR_DATA: begin
          d.rdata = 32'(q.rx_data);
          d.rx_valid = 1'b0;
        end
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Choose the set the engines run on from the stored set and select input.
    use_stored = !q.sel_s[SEL_EN_BIT] || q.mi_s[q.sel_s[3:0]];       // [R09] [R10]
    d.act_cfg = use_stored ? q.cfg_s : CFG_RESET;
    d.act_tmo = use_stored ? q.tmo_s : TMO_RESET;
    d.act_net = use_stored ? q.net_s : NET_RESET;                    // [R08]

    // Receive timeout in 10 ms steps, restarted by every character.
    if (rx_done) begin
      d.armed = (q.act_tmo != 8'h0);                                 // [R07] [R16]
      d.tick = 32'h0;
      d.units = 8'h0;
    end else if (q.armed) begin
      if (q.act_tmo == 8'h0) begin
        d.armed = 1'b0;                                              // [R07]
      end else if (q.tick == 32'(STEP_CYCLES - 1)) begin
        d.tick = 32'h0;
        d.units = q.units + 8'h1;
        if (q.units + 8'h1 == q.act_tmo) begin
          d.tmo_err = 1'b1;                                          // [R06] [R16]
          d.armed = 1'b0;
        end
      end else begin
        d.tick = q.tick + 32'h1;
      end
    end

    // Received characters; the event sets win over a clear in the same cycle.
    if (rx_done) begin
      d.rx_valid = 1'b1;
      d.rx_data = rx_byte;
      if (rx_perr) begin
        d.perr = 1'b1;                                               // [R17]
      end
    end

    d.awready = !d.aw_held;
    d.wready = !d.w_held;
    d.arready = !d.rvalid;
  end

  // ********************
  // State register
  // ********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign net_number = q.act_net;

endmodule

// [core/maint_port_pkg.sv]
// Shared constants of the serial port: map, fields, resets, timing.
// Assumes one 250 MHz clock and a 32-bit AXI4-Lite master.
//
// Functional notes
// R01 - Ports number 3 to 7 in mounting order.
// R02 - Eight rates, 1200 to 115200 bit/s, 9600 by default.
// R03 - 7 or 8 data bits, 7 by default.
// R04 - Even, odd or no parity, even by default.
// R05 - 1 or 2 stop bits, 1 by default.
// R06 - Timeout 10 to 2550 ms in 10 ms steps, 500 ms default.
// R07 - Timeout setting zero disables timeout detection.
// R08 - Network number 0 to 31, 0 by default.
// R09 - Assigned select input: parameters apply only while it is on.
// R10 - No select input: loaded parameters apply at once.
// R11 - Settings load only with a program sent via built-in port 1 or 2.
// R12 - A program load stores all accompanying settings.
// R13 - Run-time program load refused on ports 3 to 7.
// R14 - Host uses ASCII mode for program transfer.
// R15 - Two fastest rates need firmware 220 or later and a fast module.
// R16 - Timeout restarts per received character and flags expiry.
// R17 - Received parity mismatch flags an error.
package maint_port_pkg;

  // ********************
  // Timing
  // ********************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TIMEOUT_STEP_MS = 10;
  localparam int unsigned TIMEOUT_STEP_CYCLES = CLK_HZ / 1000 * TIMEOUT_STEP_MS;
  // Bit period in clock cycles for each rate choice, rounded down.
  localparam logic [17:0] BAUD_DIV [8] = '{
    18'(CLK_HZ / 1200), 18'(CLK_HZ / 2400), 18'(CLK_HZ / 4800), 18'(CLK_HZ / 9600),
    18'(CLK_HZ / 19200), 18'(CLK_HZ / 38400), 18'(CLK_HZ / 57600), 18'(CLK_HZ / 115200)};
  localparam logic [2:0] BAUD_FAST_MIN = 3'h6;
  localparam int unsigned FW_FAST_MIN = 220;

  // ********************
  // Port numbering and load sources
  // ********************
  localparam int unsigned FIRST_PORT = 3;
  localparam int unsigned LAST_PORT = 7;
  localparam logic [2:0] LOAD_PORT_A = 3'h1;
  localparam logic [2:0] LOAD_PORT_B = 3'h2;

  // ********************
  // Register map and fields
  // ********************
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_TMO = 8'h04;
  localparam logic [7:0] ADDR_NET = 8'h08;
  localparam logic [7:0] ADDR_SEL = 8'h0C;
  localparam logic [7:0] ADDR_LOAD = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;
  localparam int unsigned CFG_BAUD_LSB = 0;
  localparam int unsigned CFG_DATA8_BIT = 3;
  localparam int unsigned CFG_PAR_LSB = 4;
  localparam int unsigned CFG_STOP2_BIT = 6;
  localparam int unsigned SEL_EN_BIT = 4;
  localparam int unsigned LOAD_RUN_BIT = 3;
  localparam int unsigned ST_PERR_BIT = 3;
  localparam int unsigned ST_TMO_BIT = 4;
  localparam int unsigned ST_REJ_BIT = 5;
  localparam int unsigned ST_RXV_BIT = 6;
  localparam int unsigned ST_TXB_BIT = 7;
  localparam int unsigned ST_FAST_BIT = 8;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************
  // Reset values
  // ********************
  localparam logic [6:0] CFG_RESET = 7'h13;
  localparam logic [7:0] TMO_RESET = 8'h32;
  localparam logic [4:0] NET_RESET = 5'h00;
  localparam logic [4:0] SEL_RESET = 5'h00;

endpackage

// [core/serial_tx.sv]
// Character transmitter: start bit, 7 or 8 data bits LSB first, optional parity, stop bits.
// Assumes the settings stay still while a character is being sent.
`timescale 1ns/100ps
module serial_tx import maint_port_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] div,
  input wire logic data8,
  input wire logic [1:0] parity,
  input wire logic stop2,
  input wire logic start,
  input wire logic [7:0] data,
  output logic txd,
  output logic busy
);

  typedef struct packed {
    logic [11:0] sh;
    logic [3:0] left;
    logic [17:0] cnt;
    logic busy;
    logic txd;
  } tx_s;

  tx_s q;
  tx_s d;
  logic [11:0] fr;
  logic [3:0] nd;
  logic pb;

  // Build the whole frame at start, then shift it out one bit period at a time.
  always_comb begin
    nd = data8 ? 4'h8 : 4'h7;                                      // [R03]
    pb = (data8 ? ^data : ^data[6:0]) ^ (parity == PAR_ODD);       // [R04]
    fr = 12'hFFF;
    fr[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nd)) begin
        fr[i + 1] = data[i];
      end
    end
    if (parity != PAR_NONE) begin
      fr[nd + 4'h1] = pb;                                          // [R04]
    end
    d = q;
    if (!q.busy) begin
      d.txd = 1'b1;
      if (start) begin
        d.busy = 1'b1;
        d.txd = 1'b0;
        d.sh = {1'b1, fr[11:1]};
        d.cnt = '0;
        d.left = nd + ((parity != PAR_NONE) ? 4'h2 : 4'h1) + (stop2 ? 4'h2 : 4'h1); // [R05]
      end
    end else if (q.cnt == div - 18'h1) begin
      d.cnt = '0;
      d.left = q.left - 4'h1;
      if (q.left == 4'h1) begin
        d.busy = 1'b0;
        d.txd = 1'b1;
      end else begin
        d.txd = q.sh[0];
        d.sh = {1'b1, q.sh[11:1]};
      end
    end else begin
      d.cnt = q.cnt + 18'h1;
    end
  end

  // State register; the line idles high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{sh: 12'hFFF, left: 4'h0, cnt: 18'h0, busy: 1'b0, txd: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign txd = q.txd;
  assign busy = q.busy;

endmodule

// [core/serial_rx.sv]
// Character receiver with parity check; samples each bit in its middle.
// Assumes rxd is already synchronised to aclk.
`timescale 1ns/100ps
module serial_rx import maint_port_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] div,
  input wire logic data8,
  input wire logic [1:0] parity,
  input wire logic rxd,
  output logic done,
  output logic [7:0] data,
  output logic perr
);

  typedef enum logic [1:0] {S_IDLE, S_START, S_BITS, S_STOP} rx_state_e;

  typedef struct packed {
    rx_state_e st;
    logic [17:0] cnt;
    logic [3:0] idx;
    logic [9:0] sh;
    logic done;
    logic perr;
    logic [7:0] data;
  } rx_s;

  rx_s q;
  rx_s d;
  logic [3:0] nd;
  logic [3:0] nbits;
  logic [7:0] word;

  // A low level that survives to mid start bit opens a frame; glitches are dropped.
  always_comb begin
    nd = data8 ? 4'h8 : 4'h7;                                      // [R03]
    nbits = nd + ((parity != PAR_NONE) ? 4'h1 : 4'h0);
    word = data8 ? q.sh[7:0] : {1'b0, q.sh[6:0]};
    d = q;
    d.done = 1'b0;
    d.cnt = q.cnt + 18'h1;
    case (q.st)
      S_IDLE: begin
        d.cnt = '0;
        if (!rxd) begin
          d.st = S_START;
        end
      end
      S_START: begin
        if (q.cnt == {1'b0, div[17:1]}) begin
          d.cnt = '0;
          d.idx = '0;
          d.st = rxd ? S_IDLE : S_BITS;
        end
      end
      S_BITS: begin
        if (q.cnt == div - 18'h1) begin
          d.cnt = '0;
          d.sh[q.idx] = rxd;
          d.idx = q.idx + 4'h1;
          if (q.idx == nbits - 4'h1) begin
            d.st = S_STOP;
          end
        end
      end
      S_STOP: begin
        if (q.cnt == div - 18'h1) begin
          d.st = S_IDLE;
          d.done = 1'b1;
          d.data = word;
          d.perr = (parity != PAR_NONE) &&
                   ((^word ^ q.sh[nd]) != (parity == PAR_ODD));    // [R17]
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign data = q.data;
  assign perr = q.perr;

endmodule

// [bench/maint_port_asserts.sv]
// Port-level checker for the maintenance serial port, bound to every maint_port.
// Assumes one clock domain, aclk, with the synchronous active-low reset aresetn.
`timescale 1ns/100ps
module maint_port_asserts import maint_port_pkg::*; #(
  parameter int unsigned SLOT = 0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic txd
);
  typedef struct packed {logic [7:0] ra; logic [23:0] low;} mon_s;
  mon_s mon_q, mon_d;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // Helper state
  // ****
  // Remembers the read address and how long txd has stayed low.
  always_comb begin
    mon_d = mon_q;
    if (arvalid && arready) mon_d.ra = araddr;
    mon_d.low = txd ? 24'h0 : mon_q.low + 24'h1;
  end
  // Registers the helper state.
  always_ff @(posedge aclk) begin
    if (!aresetn) mon_q <= '0;
    else mon_q <= mon_d;
  end
  // ****
  // Properties
  // ****
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  AST_B_LAT: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed while waiting");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  AST_ERR_ZERO: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("refused read carried data");
  AST_PORT_NUM: assert property (rvalid && mon_q.ra == ADDR_STAT
    |-> rdata[2:0] == 3'(FIRST_PORT + SLOT)) else $error("wrong port number");
  AST_LOAD_WO: assert property (rvalid && mon_q.ra == ADDR_LOAD |-> rdata == 32'h0)
    else $error("load register read back");
  AST_BIT_LEN: assert property ($rose(txd) |-> mon_q.low >= 24'(BAUD_DIV[7]) - 24'h2)
    else $error("low bit shorter than fastest rate");
endmodule

bind maint_port maint_port_asserts #(.SLOT(SLOT)) u_maint_port_asserts (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .txd(txd));

// [bench/host_serial_model.sv]
// Host serial partner: sends frames and decodes the port's.
// Assumes BIT equals the port's bit period.
`timescale 1ns/100ps
module host_serial_model import maint_port_pkg::*; #(
  parameter int unsigned BIT = 2170
) (
  input wire logic aclk,
  input wire logic txd,
  input wire logic bits8,
  input wire logic [1:0] par,
  output logic rxd
);
  logic [7:0] got;
  logic got_par;
  logic [1:0] got_stop;
  int n_got = 0;
  initial rxd = 1'b1;
  // Expected parity bit.
  function automatic logic par_of(input logic [7:0] c);
    return (bits8 ? ^c : ^c[6:0]) ^ (par == PAR_ODD);
  endfunction
  // Holds one line level for a full bit period.
  task automatic put(input logic b);
    rxd <= b;
    repeat (BIT) @(posedge aclk);
  endtask
  // ASCII codes only; bad flips parity.
  task automatic send(input logic [7:0] c, input logic bad);
    @(posedge aclk);
    put(1'b0);
    for (int i = 0; i < (bits8 ? 8 : 7); i++) put(c[i]);
    if (par != PAR_NONE) put(par_of(c) ^ bad);
    put(1'b1);
  endtask
  // Mid-bit decoder; keeps two stop slots.
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    got = 8'h00;
    for (int i = 0; i < (bits8 ? 8 : 7); i++) begin
      repeat (BIT) @(posedge aclk);
      got[i] = txd;
    end
    if (par != PAR_NONE) begin
      repeat (BIT) @(posedge aclk);
      got_par = txd;
    end
    for (int i = 0; i < 2; i++) begin
      repeat (BIT) @(posedge aclk);
      got_stop[i] = txd;
    end
    n_got++;
  end
endmodule

// [bench/tb_maint_port.sv]
// Bench for maint_port: AXI4-Lite master and serial host.
// Assumes a 4 ns clock and a timeout step of STEP cycles.
`timescale 1ns/100ps
module tb_maint_port import maint_port_pkg::*;;
  localparam int unsigned SLOT = 2;
  localparam int unsigned STEP = 50;
  localparam logic [2:0] BAD_SRC [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd, txd, bits8 = 1'b0;
  logic [1:0] bresp, rresp, par = PAR_EVEN;
  logic [15:0] mode_in = 16'h0000;
  logic [4:0] net_number;
  int checks = 0, miscompares = 0;
  maint_port #(.SLOT(SLOT), .STEP_CYCLES(STEP)) u_maint_port (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd(rxd), .txd(txd), .mode_in(mode_in), .net_number(net_number));
  host_serial_model #(.BIT(BAUD_DIV[7])) u_host_serial_model (
    .aclk(aclk), .txd(txd), .bits8(bits8), .par(par), .rxd(rxd));
  // A 4 ns clock.
  initial forever #2 aclk = ~aclk;
  // ****
  // Expectations and checks
  // ****
  function automatic logic [31:0] cfg_w(int b, logic d8, logic [1:0] p, logic s2);
    return 32'(b) | {d8, 3'h0} | {p, 4'h0} | {s2, 6'h0};
  endfunction
  function automatic logic exp_par(logic [7:0] c, logic d8, logic [1:0] p);
    return (d8 ? ^c : ^c[6:0]) ^ (p == PAR_ODD);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // ****
  // Bus master
  // ****
  // AW and W offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      pa = pa && (awready !== 1'b1);
      pw = pw && (wready !== 1'b1);
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wo(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic st(input int b, input logic e);
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_STAT, d, r);
    chk(d[b], e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well past two frames.
  initial begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end
  // ****
  // Tests
  // ****
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] a, c, tx;
    logic [4:0] n, m;
    int k, t;
    void'($urandom(32'h0D29));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ADDR_CFG, cfg_w(3, 1'b0, PAR_EVEN, 1'b0));
    rc(ADDR_TMO, 32'(500 / TIMEOUT_STEP_MS));
    rc(ADDR_NET, 32'h0);
    rc(ADDR_SEL, 32'h0);
    rc(ADDR_STAT, 32'(FIRST_PORT + SLOT));
    $display("test reset done");
    a = 8'h1C + 8'(4 * ($urandom % 57));
    wr(a, $urandom, r);
    chk(r, RESP_SLVERR);
    rd(a, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    $display("test unmapped done");
    n = 5'(1 + $urandom % 31);
    wo(ADDR_NET, 32'(n));
    foreach (BAD_SRC[i]) begin
      wo(ADDR_LOAD, 32'(BAD_SRC[i]));
      st(ST_REJ_BIT, 1'b1);
      chk(net_number, 5'h00);
      wo(ADDR_STAT, 32'h20);
    end
    st(ST_REJ_BIT, 1'b0);
    wo(ADDR_LOAD, 32'h1);
    repeat (2) @(posedge aclk);
    chk(net_number, n);
    $display("test load done");
    k = $urandom % 16;
    m = 5'(1 + $urandom % 31);
    wo(ADDR_SEL, 32'h10 | 32'(k));
    wo(ADDR_NET, 32'(m));
    wo(ADDR_LOAD, 32'h2);
    repeat (5) @(posedge aclk);
    chk(net_number, 5'h00);
    mode_in <= 16'h1 << k;
    repeat (5) @(posedge aclk);
    chk(net_number, m);
    mode_in <= 16'($urandom) & ~(16'h1 << k);
    repeat (5) @(posedge aclk);
    chk(net_number, 5'h00);
    wo(ADDR_SEL, 32'h0);
    $display("test select done");
    c = 8'($urandom % 128);
    tx = 8'($urandom);
    wo(ADDR_CFG, cfg_w(7, 1'b1, PAR_ODD, 1'b1));
    wo(ADDR_TMO, 32'h1);
    wo(ADDR_LOAD, 32'h1);
    bits8 <= 1'b1;
    par <= PAR_ODD;
    st(ST_FAST_BIT, 1'b0);
    t = u_host_serial_model.n_got;
    fork
      wo(ADDR_DATA, 32'(tx));
      u_host_serial_model.send(c, 1'b0);
    join
    wait (u_host_serial_model.n_got > t);
    chk(u_host_serial_model.got, tx);
    chk(u_host_serial_model.got_par, exp_par(tx, 1'b1, PAR_ODD));
    chk(u_host_serial_model.got_stop, 2'h3);
    st(ST_RXV_BIT, 1'b1);
    rc(ADDR_DATA, 32'(c));
    st(ST_PERR_BIT, 1'b0);
    st(ST_TMO_BIT, 1'b1);
    $display("test serial done");
    wo(ADDR_STAT, 32'h138);
    wo(ADDR_TMO, 32'h0);
    wo(ADDR_CFG, cfg_w(7, 1'b0, PAR_EVEN, 1'b0));
    wo(ADDR_LOAD, 32'h1);
    bits8 <= 1'b0;
    par <= PAR_EVEN;
    c = 8'($urandom % 128);
    u_host_serial_model.send(c, 1'b1);
    repeat (4 * STEP) @(posedge aclk);
    st(ST_PERR_BIT, 1'b1);
    rc(ADDR_DATA, 32'(c & 8'h7F));
    st(ST_TMO_BIT, 1'b0);
    $display("test parity done");
    report_and_stop;
  end
endmodule
